// ===== fmsp_pkg.sv
// Shared constants and types for the flash mode select and protect block
package fmsp_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS     = 50;  // System clock period
    localparam int MODE_SETUP_STATES = 4;   // Pins settle this many states before reset ends
    localparam int ZERO_LOW_BITS     = 9;   // Start bit plus eight zero data bits stay low
    localparam int MIN_BIT_CYCLES    = 4;   // Shortest bit accepted by the rate match
    localparam int LEN_BYTES         = 2;   // Load length header, high byte first

    // ----------------------------------------
    // Serial format and reset values
    // ----------------------------------------
    localparam int         DATA_BITS  = 8;
    localparam int         FRAME_BITS = 10;       // Start, eight data, one stop, no parity
    localparam logic [7:0] ACK_BYTE   = 8'h00;    // Sent back once the rate is matched
    localparam logic [7:0] EBR_RESET  = 8'h00;    // Erase block protect after reset

    // ----------------------------------------
    // State types
    // ----------------------------------------
    typedef enum logic [3:0] {
        MODE_NONE = 4'h1,
        MODE_USER = 4'h2,
        MODE_BOOT = 4'h4,
        MODE_PROG = 4'h8
    } fmsp_mode_t;

    typedef enum logic [5:0] {
        BT_OFF     = 6'h01,
        BT_IDLE    = 6'h02,
        BT_MEASURE = 6'h04,
        BT_LOAD    = 6'h08,
        BT_ERASE   = 6'h10,
        BT_RUN     = 6'h20
    } fmsp_boot_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } fmsp_rx_t;
endpackage : fmsp_pkg

// ===== fmsp_byte_if.sv
// Valid/ready byte stream between the loader and its buffer
`timescale 1ns/1ps
`default_nettype none
interface fmsp_byte_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : fmsp_byte_if
`default_nettype wire

// ===== fmsp_buf2.sv
// Two-entry buffer on the received byte path
`timescale 1ns/1ps
`default_nettype none
module fmsp_buf2 #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic      clock,
    input  wire logic      rstn,
    // Stream sides
    fmsp_byte_if.snk       in_port,
    fmsp_byte_if.src       out_port
);
    logic [W-1:0] mem [2];
    logic         wr_ptr;
    logic         rd_ptr;
    logic [1:0]   count;
    logic         push;
    logic         pop;

    // Full and empty follow the count directly
    assign in_port.ready  = (count != 2'h2);
    assign out_port.valid = (count != 2'h0);
    assign out_port.data  = mem[rd_ptr];
    assign push           = in_port.valid & in_port.ready;
    assign pop            = out_port.valid & out_port.ready;

    // Storage; a push and a pop in one cycle keep the count
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_port.data;
                wr_ptr      <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push & ~pop) begin
                count <= count + 2'h1;
            end else if (pop & ~push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule : fmsp_buf2
`default_nettype wire

// ===== fmsp_top.sv
// Flash mode selection, boot loader front end and program/erase protection
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Mode pins pick user, boot or programmer
// - Boot mode loads control program into RAM
// - Boot mode erases whole flash before running
// - Serial link is 8 data, 1 stop, no parity
// - Zero bytes measured to match host bit rate
// - User mode programs and erases single blocks
// - Low power or reset aborts program/erase
// - Those transitions reinitialise control registers
// - Cleared write enable blocks program/erase entry
// - Erase protect per block; zero protects all
// - Reading busy flash area flags an error
// - Exception during operation flags an error
// - Sleep during operation flags an error
// - Error keeps registers, ends mode at once
module fmsp_top #(
    parameter int BLOCKS  = 8,
    parameter int BLK_W   = 3,
    parameter int RAM_AW  = 11,
    parameter int CNT_W   = 16
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // Mode pins
    input  wire logic              test_pin,
    input  wire logic              nmi_n_pin,
    input  wire logic              boot_select_pin,
    input  wire logic              prog_select_pin_a,
    input  wire logic              prog_select_pin_b,
    input  wire logic              prog_select_pin_c,
    // Serial link
    input  wire logic              rxd,
    output logic                   txd,
    // Power mode transitions
    input  wire logic              enter_subactive,
    input  wire logic              enter_subsleep,
    input  wire logic              enter_standby,
    // CPU events
    input  wire logic              cpu_read,
    input  wire logic [BLK_W-1:0]  cpu_read_block,
    input  wire logic              exception_taken,
    input  wire logic              sleep_exec,
    // Control writes
    input  wire logic              ctl_write,
    input  wire logic              ctl_swe,
    input  wire logic              ctl_program,
    input  wire logic              ctl_erase,
    input  wire logic              ebr_write,
    input  wire logic [BLOCKS-1:0] ebr_data,
    input  wire logic [BLK_W-1:0]  prog_block,
    // Boot loader side
    input  wire logic              ram_ready,
    output logic                   ram_we,
    output logic [RAM_AW-1:0]      ram_addr,
    output logic [7:0]             ram_data,
    output logic                   erase_all_req,
    input  wire logic              erase_all_done,
    output logic                   boot_run,
    // Status
    output logic                   mode_user,
    output logic                   mode_boot,
    output logic                   mode_programmer,
    output logic                   software_write_enable,
    output logic                   program_bit,
    output logic                   erase_bit,
    output logic [BLOCKS-1:0]      erase_block_protect_reg,
    output logic                   program_mode,
    output logic                   erase_mode,
    output logic                   flash_error_flag,
    output logic                   rx_overrun
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic block_hit(input logic [BLOCKS-1:0] mask, input logic [BLK_W-1:0] idx);
        block_hit = mask[idx];
    endfunction : block_hit

    localparam logic [CNT_W-1:0] MIN_BIT = CNT_W'(fmsp_pkg::MIN_BIT_CYCLES);
    localparam logic [CNT_W-1:0] LOW_DIV = CNT_W'(fmsp_pkg::ZERO_LOW_BITS);

    fmsp_pkg::fmsp_mode_t mode;
    fmsp_pkg::fmsp_boot_t boot_state;
    fmsp_pkg::fmsp_rx_t   rx_state;
    logic                 hw_protect;
    logic                 rxd_q;
    logic                 armed;
    logic [CNT_W-1:0]     low_cnt;
    logic [CNT_W-1:0]     bit_cycles;
    logic                 next_program_mode;
    logic                 next_erase_mode;
    logic                 flash_allowed;
    logic                 read_hit;
    logic                 error_event;

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    // Pins are caught on the first edge after release that selects a mode, never inside reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mode <= fmsp_pkg::MODE_NONE;
        end else if (mode == fmsp_pkg::MODE_NONE) begin
            if (!test_pin && nmi_n_pin) begin
                mode <= fmsp_pkg::MODE_USER;
            end else if (!test_pin && boot_select_pin) begin
                mode <= fmsp_pkg::MODE_BOOT;
            end else if (test_pin && !prog_select_pin_a && !prog_select_pin_b && !prog_select_pin_c) begin
                mode <= fmsp_pkg::MODE_PROG;
            end
        end
    end

    assign mode_user       = (mode == fmsp_pkg::MODE_USER);
    assign mode_boot       = (mode == fmsp_pkg::MODE_BOOT);
    assign mode_programmer = (mode == fmsp_pkg::MODE_PROG);

    // ----------------------------------------
    // Control registers and hardware protection
    // ----------------------------------------
    assign hw_protect = enter_subactive | enter_subsleep | enter_standby;

    // Low power entry clears the registers just as reset does
    always_ff @(posedge clock) begin
        if (!rstn || hw_protect) begin
            software_write_enable   <= 1'b0;
            program_bit             <= 1'b0;
            erase_bit               <= 1'b0;
            erase_block_protect_reg <= BLOCKS'(fmsp_pkg::EBR_RESET);
        end else begin
            if (ctl_write) begin
                software_write_enable <= ctl_swe;
                program_bit           <= ctl_program;
                erase_bit             <= ctl_erase;
            end
            if (ebr_write) begin
                erase_block_protect_reg <= ebr_data;
            end
        end
    end

    // ----------------------------------------
    // Program/erase mode and error protection
    // ----------------------------------------
    // Boot mode only opens the flash once the downloaded program runs
    assign flash_allowed = mode_user | mode_programmer | (mode_boot & (boot_state == fmsp_pkg::BT_RUN));

    // A read of the block under work; erase covers every unprotected block
    assign read_hit = cpu_read & (erase_mode ? block_hit(erase_block_protect_reg, cpu_read_block)
                                             : (cpu_read_block == prog_block));
    assign error_event = (program_mode | erase_mode) &
                         (read_hit | exception_taken | sleep_exec);

    // Bits stay stored; only the active mode drops, so the error ends it at once
    always_comb begin
        next_program_mode = program_bit & ~erase_bit & software_write_enable;
        next_erase_mode   = erase_bit & ~program_bit & software_write_enable &
                            (erase_block_protect_reg != '0);
        if (!flash_allowed || flash_error_flag || error_event || hw_protect) begin
            next_program_mode = 1'b0;
            next_erase_mode   = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            program_mode <= 1'b0;
            erase_mode   <= 1'b0;
        end else begin
            program_mode <= next_program_mode;
            erase_mode   <= next_erase_mode;
        end
    end

    // Error flag is sticky; only reset or low power entry clears it
    always_ff @(posedge clock) begin
        if (!rstn || hw_protect) begin
            flash_error_flag <= 1'b0;
        end else if (error_event) begin
            flash_error_flag <= 1'b1;
        end
    end

    // ----------------------------------------
    // Boot sequencer and rate match
    // ----------------------------------------
    logic                 tx_start;
    logic                 hdr_done;
    logic                 load_done;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rxd_q <= 1'b1;
        end else begin
            rxd_q <= rxd;
        end
    end

    // Low time of a zero byte spans nine bit times
    always_ff @(posedge clock) begin
        if (!rstn) begin
            boot_state <= fmsp_pkg::BT_OFF;
            armed      <= 1'b0;
            low_cnt    <= '0;
            bit_cycles <= '0;
            tx_start   <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            case (boot_state)
                fmsp_pkg::BT_OFF: begin
                    if (mode_boot) begin
                        boot_state <= fmsp_pkg::BT_IDLE;
                    end
                end
                fmsp_pkg::BT_IDLE: begin
                    // A line low since release is not taken as a start bit
                    if (rxd_q) begin
                        armed <= 1'b1;
                    end else if (armed) begin
                        low_cnt    <= CNT_W'(1);
                        boot_state <= fmsp_pkg::BT_MEASURE;
                    end
                end
                fmsp_pkg::BT_MEASURE: begin
                    if (!rxd_q) begin
                        if (low_cnt != '1) begin
                            low_cnt <= low_cnt + CNT_W'(1);
                        end
                    end else if ((low_cnt / LOW_DIV) >= MIN_BIT) begin
                        bit_cycles <= low_cnt / LOW_DIV;
                        tx_start   <= 1'b1;
                        boot_state <= fmsp_pkg::BT_LOAD;
                    end else begin
                        boot_state <= fmsp_pkg::BT_IDLE;
                    end
                end
                fmsp_pkg::BT_LOAD: begin
                    if (load_done) begin
                        boot_state <= fmsp_pkg::BT_ERASE;
                    end
                end
                fmsp_pkg::BT_ERASE: begin
                    if (erase_all_done && !hw_protect) begin
                        boot_state <= fmsp_pkg::BT_RUN;
                    end
                end
                fmsp_pkg::BT_RUN: begin
                    boot_state <= fmsp_pkg::BT_RUN;
                end
                default: begin
                    boot_state <= fmsp_pkg::BT_OFF;
                end
            endcase
        end
    end

    // Whole-array erase is withheld while a low power mode is entered
    assign erase_all_req = (boot_state == fmsp_pkg::BT_ERASE) & ~hw_protect;
    assign boot_run      = (boot_state == fmsp_pkg::BT_RUN);

    // ----------------------------------------
    // Acknowledge transmitter
    // ----------------------------------------
    logic [fmsp_pkg::FRAME_BITS-1:0] tx_shift;
    logic [3:0]                      tx_left;
    logic [CNT_W-1:0]                tx_cnt;

    // One zero byte tells the host the rate is matched
    always_ff @(posedge clock) begin
        if (!rstn) begin
            tx_shift <= '1;
            tx_left  <= 4'h0;
            tx_cnt   <= '0;
        end else if (tx_start) begin
            tx_shift <= {1'b1, fmsp_pkg::ACK_BYTE, 1'b0};
            tx_left  <= 4'(fmsp_pkg::FRAME_BITS);
            tx_cnt   <= bit_cycles - CNT_W'(1);
        end else if (tx_left != 4'h0) begin
            if (tx_cnt == '0) begin
                tx_shift <= {1'b1, tx_shift[fmsp_pkg::FRAME_BITS-1:1]};
                tx_left  <= tx_left - 4'h1;
                tx_cnt   <= bit_cycles - CNT_W'(1);
            end else begin
                tx_cnt <= tx_cnt - CNT_W'(1);
            end
        end
    end

    assign txd = tx_shift[0];

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    fmsp_byte_if #(.W(8)) rx_if ();
    fmsp_byte_if #(.W(8)) ram_if ();

    logic [CNT_W-1:0] rx_cnt;
    logic [2:0]       rx_bits;
    logic [7:0]       rx_shift;
    logic             rx_push;
    logic [7:0]       rx_byte;

    // Centre sampling from half a bit after the falling edge
    always_ff @(posedge clock) begin
        if (!rstn || boot_state != fmsp_pkg::BT_LOAD) begin
            rx_state <= fmsp_pkg::RX_IDLE;
            rx_cnt   <= '0;
            rx_bits  <= 3'h0;
            rx_shift <= 8'h00;
            rx_push  <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            rx_push <= 1'b0;
            case (rx_state)
                fmsp_pkg::RX_IDLE: begin
                    if (!rxd_q) begin
                        rx_cnt   <= bit_cycles >> 1;
                        rx_state <= fmsp_pkg::RX_START;
                    end
                end
                fmsp_pkg::RX_START: begin
                    if (rx_cnt != '0) begin
                        rx_cnt <= rx_cnt - CNT_W'(1);
                    end else if (!rxd_q) begin
                        rx_cnt   <= bit_cycles - CNT_W'(1);
                        rx_bits  <= 3'h0;
                        rx_state <= fmsp_pkg::RX_DATA;
                    end else begin
                        rx_state <= fmsp_pkg::RX_IDLE;                      // Glitch, not a start
                    end
                end
                fmsp_pkg::RX_DATA: begin
                    if (rx_cnt != '0) begin
                        rx_cnt <= rx_cnt - CNT_W'(1);
                    end else begin
                        rx_shift <= {rxd_q, rx_shift[7:1]};
                        rx_bits  <= rx_bits + 3'h1;
                        rx_cnt   <= bit_cycles - CNT_W'(1);
                        if (rx_bits == 3'(fmsp_pkg::DATA_BITS - 1)) begin
                            rx_state <= fmsp_pkg::RX_STOP;
                        end
                    end
                end
                fmsp_pkg::RX_STOP: begin
                    if (rx_cnt != '0) begin
                        rx_cnt <= rx_cnt - CNT_W'(1);
                    end else begin
                        rx_push  <= rxd_q;
                        rx_byte  <= rx_shift;
                        rx_state <= fmsp_pkg::RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= fmsp_pkg::RX_IDLE;
                end
            endcase
        end
    end

    assign rx_if.valid = rx_push;
    assign rx_if.data  = rx_byte;

    // A byte that meets a full buffer is lost and reported
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rx_overrun <= 1'b0;
        end else if (rx_push && !rx_if.ready) begin
            rx_overrun <= 1'b1;
        end
    end

    fmsp_buf2 #(.W(8)) u_buf (
        .clock    (clock),
        .rstn     (rstn),
        .in_port  (rx_if),
        .out_port (ram_if)
    );

    // ----------------------------------------
    // RAM loader
    // ----------------------------------------
    logic [1:0]  hdr_left;
    logic [15:0] load_len;
    logic [15:0] load_cnt;

    assign hdr_done     = (hdr_left == 2'h0);
    assign load_done    = hdr_done & (load_cnt == load_len);
    // RAM stalls hold bytes in the buffer; header bytes are always taken
    assign ram_if.ready = (boot_state == fmsp_pkg::BT_LOAD) & (~hdr_done | (ram_ready & ~load_done));
    assign ram_we       = ram_if.valid & ram_if.ready & hdr_done;
    assign ram_data     = ram_if.data;
    assign ram_addr     = load_cnt[RAM_AW-1:0];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            hdr_left <= 2'(fmsp_pkg::LEN_BYTES);
            load_len <= 16'h0000;
            load_cnt <= 16'h0000;
        end else if (ram_if.valid && ram_if.ready) begin
            if (!hdr_done) begin
                load_len <= {load_len[7:0], ram_if.data};
                hdr_left <= hdr_left - 2'h1;
            end else begin
                load_cnt <= load_cnt + 16'h0001;
            end
        end
    end
endmodule : fmsp_top
`default_nettype wire

// ===== fmsp_chk.sv
// Assertion checker for the flash mode select and protect block
`timescale 1ns/1ps
`default_nettype none
module fmsp_chk #(parameter int BLOCKS = 8) (
    // Clock, reset and mode pins
    input wire logic              clock,
    input wire logic              rstn,
    input wire logic              test_pin,
    input wire logic              nmi_n_pin,
    // Events
    input wire logic              enter_subactive,
    input wire logic              enter_subsleep,
    input wire logic              enter_standby,
    input wire logic              exception_taken,
    input wire logic              sleep_exec,
    // Status
    input wire logic              erase_all_req,
    input wire logic              boot_run,
    input wire logic              mode_user,
    input wire logic              software_write_enable,
    input wire logic [BLOCKS-1:0] erase_block_protect_reg,
    input wire logic              program_mode,
    input wire logic              erase_mode,
    input wire logic              flash_error_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Any low power entry counts as hardware protection, which outranks errors
    wire hp   = enter_subactive | enter_subsleep | enter_standby;
    wire busy = program_mode | erase_mode;
    a_sleep_sets_error: assert property (busy && sleep_exec && !hp |=> flash_error_flag && !busy)
        else $error("sleep during operation not flagged");
    a_exc_sets_error: assert property (busy && exception_taken && !hp |=> flash_error_flag && !busy)
        else $error("exception during operation not flagged");
    a_error_stays_locked: assert property (flash_error_flag && !hp |=> flash_error_flag && !busy)
        else $error("error lock released early");
    a_swe_gates_modes: assert property (!software_write_enable |=> !busy)
        else $error("mode entered without write enable");
    a_ebr_zero_protects: assert property (erase_block_protect_reg == '0 |=> !erase_mode)
        else $error("erase mode with all blocks protected");
    a_hw_clears_regs: assert property (hp |=> !software_write_enable && erase_block_protect_reg == '0
        && !flash_error_flag) else $error("protection did not reinitialise");
    a_hw_aborts_mode: assert property (hp |=> !busy)
        else $error("protection did not abort operation");
    a_user_decode: assert property ($rose(rstn) |=> mode_user == (!$past(test_pin) && $past(nmi_n_pin)))
        else $error("user mode decode wrong");
    a_erase_before_run: assert property ($rose(boot_run) |-> $past(erase_all_req))
        else $error("boot program ran before erase");
    c_program: cover property (program_mode);
    c_error: cover property ($rose(flash_error_flag));
    c_boot_run: cover property ($rose(boot_run));
endmodule : fmsp_chk
bind fmsp_top fmsp_chk #(.BLOCKS(BLOCKS)) fmsp_chk_i (.*);
`default_nettype wire

// ===== fmsp_host.sv
// Serial host model driving the receive line in boot mode
`timescale 1ns/1ps
`default_nettype none
module fmsp_host #(parameter int BIT = 8) (
    // Clock and line
    input wire logic clock,
    output var logic rxd
);
    // Line rests high, also when reset ends into boot mode
    initial rxd = 1'h1;
    // One frame, LSB first; caller enters just after a rising edge
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge clock);
        end
    endtask : send
endmodule : fmsp_host
`default_nettype wire

// ===== fmsp_top_bench.sv
// Self-checking bench for the flash mode select and protect block
`timescale 1ns/1ps
`default_nettype none
module fmsp_top_bench;
    logic clock = 1'h0, rstn = 1'h0, test_pin = 1'h0, nmi_n_pin = 1'h1, boot_select_pin = 1'h0;
    logic prog_select_pin_a = 1'h0, prog_select_pin_b = 1'h0, prog_select_pin_c = 1'h0, rxd, txd;
    logic enter_subactive = 1'h0, enter_subsleep = 1'h0, enter_standby = 1'h0, cpu_read = 1'h0;
    logic exception_taken = 1'h0, sleep_exec = 1'h0, ctl_write = 1'h0, ctl_swe = 1'h0, ctl_program = 1'h0;
    logic ctl_erase = 1'h0, ebr_write = 1'h0, ram_ready = 1'h1, erase_all_done = 1'h0, ram_we, boot_run;
    logic [2:0] cpu_read_block = 3'h2, prog_block = 3'h2;
    logic [7:0] ebr_data = 8'h00, ram_data, erase_block_protect_reg;
    logic [10:0] ram_addr;
    logic erase_all_req, mode_user, mode_boot, mode_programmer, software_write_enable, program_bit;
    logic erase_bit, program_mode, erase_mode, flash_error_flag, rx_overrun;
    int bad_count = 0, tests_run = 0, cyc = 0;
    always #25 clock = ~clock;
    fmsp_top fmsp_top_i (.*);
    fmsp_host fmsp_host_i (.clock, .rxd);
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // Reset with pins settled well ahead of release; mode latches on the first edge after
    task automatic boot_with(input logic [5:0] p);
        @(posedge clock);
        rstn <= 1'h0;
        {test_pin, nmi_n_pin, boot_select_pin, prog_select_pin_a, prog_select_pin_b, prog_select_pin_c} <= p;
        repeat (4) @(posedge clock);
        rstn <= 1'h1;
        repeat (2) @(posedge clock);
        #1;
    endtask : boot_with
    // Control write; returns once the active mode has had time to follow
    task automatic ctl(input logic s, input logic p, input logic e);
        @(posedge clock);
        {ctl_write, ctl_swe, ctl_program, ctl_erase} <= {1'h1, s, p, e};
        @(posedge clock);
        ctl_write <= 1'h0;
        @(posedge clock);
        #1;
    endtask : ctl
    // One-cycle pulse: 0 sleep, 1 exception, 2 flash read, 3 standby, 4 subsleep, 5 protect write
    task automatic ev(input int k);
        @(posedge clock);
        {ebr_write, enter_subsleep, enter_standby, cpu_read, exception_taken, sleep_exec} <= 6'h1 << k;
        @(posedge clock);
        {ebr_write, enter_subsleep, enter_standby, cpu_read, exception_taken, sleep_exec} <= 6'h0;
        #1;
    endtask : ev
    task automatic t_user;
        boot_with(6'h10);
        check({mode_user, mode_boot, mode_programmer}, 3'h4);
        ctl(1'h1, 1'h1, 1'h0);
        check({software_write_enable, program_bit, program_mode}, 3'h7);
        ev(0);
        check({flash_error_flag, program_mode, program_bit}, 3'h5);
        ctl(1'h1, 1'h1, 1'h0);
        check({flash_error_flag, program_mode}, 2'h2);
        ev(3);
        check({flash_error_flag, software_write_enable, program_bit}, 3'h0);
        $display("user mode test done");
    endtask : t_user
    task automatic t_prog;
        boot_with(6'h20);
        check({mode_user, mode_boot, mode_programmer}, 3'h1);
        ctl(1'h0, 1'h1, 1'h0);
        check(program_mode, 1'h0);
        ctl(1'h1, 1'h0, 1'h1);
        check({erase_bit, erase_mode}, 2'h2);
        ebr_data <= 8'h04;
        ev(5);
        @(posedge clock);
        #1;
        check(erase_mode, 1'h1);
        ev(2);
        check({flash_error_flag, erase_mode, erase_block_protect_reg}, 10'h204);
        ev(4);
        check({flash_error_flag, erase_block_protect_reg}, 9'h0);
        ctl(1'h1, 1'h1, 1'h0);
        check(program_mode, 1'h1);
        ev(3);
        check(program_mode, 1'h0);
        ctl(1'h1, 1'h1, 1'h0);
        ev(1);
        check({flash_error_flag, program_mode}, 2'h2);
        $display("programmer mode test done");
    endtask : t_prog
    task automatic t_boot;
        boot_with(6'h08);
        check(mode_boot, 1'h1);
        fork
            fmsp_host_i.send(8'h00);
            @(negedge txd);
        join_any
        repeat (4) @(negedge clock);
        for (int i = 0; i < 10; i++) begin
            check(txd, i == 9);
            repeat (8) @(negedge clock);
        end
        @(posedge clock);
        ram_ready <= 1'h0;
        fmsp_host_i.send(8'h00);
        fmsp_host_i.send(8'h01);
        fmsp_host_i.send(8'ha5);
        @(negedge clock);
        check({ram_we, rx_overrun}, 2'h0);
        @(posedge clock);
        ram_ready <= 1'h1;
        for (int n = 0; n < 300 && !ram_we; n++) @(negedge clock);
        check({ram_addr, ram_data}, 19'h000a5);
        for (int n = 0; n < 300 && !erase_all_req; n++) @(negedge clock);
        check({erase_all_req, boot_run}, 2'h2);
        @(posedge clock);
        erase_all_done <= 1'h1;
        for (int n = 0; n < 300 && !boot_run; n++) @(negedge clock);
        check(boot_run, 1'h1);
        $display("boot mode test done");
    endtask : t_boot
    // Hang guard, far above what the tests need
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        t_user();
        t_prog();
        t_boot();
        wrap_up();
    end
endmodule : fmsp_top_bench
`default_nettype wire
